// >>> rtl/prm_pkg.sv
// constants, field layout and state types of the peripheral pin router
// assumes an 8-bit register port and three 8-pin ports (A, B, C)
package prm_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SEL_W = 5;
  localparam int PORT_W = 8;
  localparam int NUM_PORTS = 3;
  localparam int NUM_PINS = NUM_PORTS * PORT_W;
  localparam int NUM_IN = 8;
  localparam int NUM_SRC = 10;
  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_LOCK = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_IN_BASE = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_OUT_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PORT_BASE = 8'h30;
  // ==========================================================
  // field positions and codes
  localparam int PORT_MSB = 4;
  localparam int PORT_LSB = 3;
  localparam int BIT_MSB = 2;
  localparam int LOCK_BIT = 0;
  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;
  localparam logic [DATA_W-1:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [DATA_W-1:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [SEL_W-1:0] OUT_LATCH = 5'h00;
  localparam logic [SEL_W-1:0] OUT_LAST = 5'h0A;
  // ==========================================================
  // reset values
  localparam logic [SEL_W-1:0] OUT_SEL_RST = 5'h00;
  localparam logic LOCK_RST = 1'b0;
  localparam logic [SEL_W-1:0] IN_SEL_RST [NUM_IN] = '{
    5'h02, 5'h02, 5'h05, 5'h04, 5'h02, 5'h0D, 5'h0F, 5'h14};
  // ==========================================================
  // unlock sequencer states
  typedef enum {PRM_IDLE, PRM_KEY1, PRM_ARMED} prm_unlock_e;
endpackage : prm_pkg

// >>> rtl/prm_in_mux.sv
// one peripheral input selector: port/bit code to pin level
// assumes pins packed as port*8+bit, all levels synchronous
`timescale 1ns/100ps
`default_nettype none
module prm_in_mux #(
  parameter bit HAS_PORT_B = 1'b1
) (
  // selection and pins
  input wire logic [prm_pkg::SEL_W-1:0] sel,
  input wire logic [prm_pkg::NUM_PINS-1:0] pin_level,
  // routed level
  output logic level
);
  import prm_pkg::*;

  // reserved port code and an absent port give a quiet zero
  always_comb begin
    level = 1'b0;
    unique case (sel[PORT_MSB:PORT_LSB])
      PORT_A, PORT_C: level = pin_level[sel];
      PORT_B: level = HAS_PORT_B ? pin_level[sel] : 1'b0;
      default: level = 1'b0;
    endcase
  end
endmodule : prm_in_mux
`default_nettype wire

// >>> rtl/prm_unlock.sv
// lock bit with its 0x55/0xAA key sequence and one-time lock option
// assumes the register port marks every strobe in its own cycle
`timescale 1ns/100ps
`default_nettype none
module prm_unlock (
  // clock and resets
  input wire logic core_clk,
  input wire logic srst,
  input wire logic dev_rst,
  // configuration
  input wire logic one_time_lock_config,
  // bus events
  input wire logic wr_lock,
  input wire logic other_access,
  input wire logic [prm_pkg::DATA_W-1:0] wr_data,
  // lock state
  output logic routing_locked_flag
);
  import prm_pkg::*;

  prm_unlock_e state, next_state;
  logic cfg_q, next_cfg_q;
  logic cleared_once, next_cleared_once;
  logic set_once, next_set_once;
  logic next_locked;
  logic want;

  // any foreign access or wrong byte drops the sequence back to idle
  always_comb begin
    next_state = PRM_IDLE;
    next_locked = routing_locked_flag;
    next_cleared_once = cleared_once;
    next_set_once = set_once;
    next_cfg_q = cfg_q;
    want = wr_data[LOCK_BIT];
    if (srst || dev_rst) begin
      next_locked = LOCK_RST;
      next_cleared_once = 1'b0;
      next_set_once = 1'b0;
      next_cfg_q = one_time_lock_config; // option caught while reset stands
    end else if (wr_lock) begin
      unique case (state)
        PRM_IDLE: next_state = (wr_data == UNLOCK_KEY1) ? PRM_KEY1 : PRM_IDLE;
        PRM_KEY1: next_state = (wr_data == UNLOCK_KEY2) ? PRM_ARMED : PRM_IDLE;
        PRM_ARMED: begin
          // one-time mode: one clear, and only before the single set of this reset
          if (!want && (!cfg_q || (!cleared_once && !set_once))) begin
            next_locked = 1'b0;
            next_cleared_once = 1'b1;
          end else if (want && (!cfg_q || !set_once)) begin
            next_locked = 1'b1;
            next_set_once = 1'b1;
          end
        end
      endcase
    end else if (!other_access) begin
      next_state = state; // idle cycles keep the sequence
    end
  end

  // registers only
  always_ff @(posedge core_clk) begin
    state <= next_state;
    routing_locked_flag <= next_locked;
    cleared_once <= next_cleared_once;
    set_once <= next_set_once;
    cfg_q <= next_cfg_q;
  end
endmodule : prm_unlock
`default_nettype wire

// >>> rtl/prm_router.sv
// peripheral pin router: input selectors, pin output selectors, lock
// assumes synchronous pins and peripherals on core_clk; srst is power-on reset
// Operation
// - only digital signals routed; analog stays fixed
// - per-input selector; many inputs may share pins
// - port reads return actual pin levels
// - input bits 4:3 pick port; 7:5 zero
// - input bits 2:0 pick bit number
// - per-pin 5-bit output selector; 7:5 zero
// - output codes: latch, comparators, pulses, serial
// - unsupported peripheral output drives zero
// - direction control drives; some peripherals override
// - lock bit blocks all selection changes
// - lock bit at bit 0; rest zero
// - lock change only after 0x55, 0xAA
// - one-time mode: clear once, set once
// - sleep leaves selections unchanged
// - power-on reset restores defaults; others keep
// - each input has its own default code
`timescale 1ns/100ps
`default_nettype none
module prm_router #(
  parameter bit HAS_PORT_B = 1'b1,
  parameter logic [prm_pkg::NUM_SRC-1:0] SRC_SUPPORTED = 10'h3FF
) (
  // clock and resets
  input wire logic core_clk,
  input wire logic srst,
  input wire logic dev_rst,
  // register port
  input wire logic [prm_pkg::ADDR_W-1:0] addr,
  input wire logic [prm_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [prm_pkg::DATA_W-1:0] rd_data,
  // configuration and status
  input wire logic one_time_lock_config,
  output logic routing_locked_flag,
  // pins
  input wire logic [prm_pkg::NUM_PINS-1:0] pin_in,
  input wire logic [prm_pkg::NUM_PINS-1:0] port_output_latch,
  input wire logic [prm_pkg::NUM_PINS-1:0] pin_direction_control,
  output logic [prm_pkg::NUM_PINS-1:0] pin_out,
  output logic [prm_pkg::NUM_PINS-1:0] pin_oe,
  // peripherals
  output logic [prm_pkg::NUM_IN-1:0] periph_in,
  input wire logic [prm_pkg::NUM_SRC-1:0] periph_out,
  input wire logic [prm_pkg::NUM_SRC-1:0] periph_drv_en,
  input wire logic [prm_pkg::NUM_SRC-1:0] periph_drv_oe
);
  import prm_pkg::*;

  // ==========================================================
  // decode
  logic [SEL_W-1:0] in_sel [NUM_IN];
  logic [SEL_W-1:0] next_in_sel [NUM_IN];
  logic [SEL_W-1:0] out_sel [NUM_PINS];
  logic [SEL_W-1:0] next_out_sel [NUM_PINS];
  logic [DATA_W-1:0] next_rd_data;
  logic [NUM_PINS-1:0] next_pin_out;
  logic [NUM_PINS-1:0] next_pin_oe;
  logic [NUM_IN-1:0] in_level;
  logic wr_lock;
  logic other_access;
  logic sel_wr_ok;

  // the lock register write feeds the sequencer; any other read or write aborts it, idle cycles do not
  assign wr_lock = wr_en && (addr == ADDR_LOCK);
  assign other_access = (wr_en || rd_en) && !wr_lock;
  // a device reset in progress also keeps selections still
  assign sel_wr_ok = wr_en && !routing_locked_flag && !dev_rst;

  // ==========================================================
  // lock
  prm_unlock u_unlock (
    .core_clk(core_clk),
    .srst(srst),
    .dev_rst(dev_rst),
    .one_time_lock_config(one_time_lock_config),
    .wr_lock(wr_lock),
    .other_access(other_access),
    .wr_data(wr_data),
    .routing_locked_flag(routing_locked_flag)
  );

  // ==========================================================
  // selector registers
  // only srst restores defaults; sleep has no path into this state
  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      next_in_sel[i] = in_sel[i];
      if (srst) begin
        next_in_sel[i] = IN_SEL_RST[i];
      end else if (sel_wr_ok && addr == ADDR_IN_BASE + ADDR_W'(i)) begin
        next_in_sel[i] = wr_data[SEL_W-1:0];
      end
    end
    for (int p = 0; p < NUM_PINS; p++) begin
      next_out_sel[p] = out_sel[p];
      if (srst) begin
        next_out_sel[p] = OUT_SEL_RST;
      end else if (sel_wr_ok && addr == ADDR_OUT_BASE + ADDR_W'(p)) begin
        next_out_sel[p] = wr_data[SEL_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    in_sel <= next_in_sel;
    out_sel <= next_out_sel;
  end

  // ==========================================================
  // input routing
  // each input has its own mux, so any number may read one pin
  for (genvar g = 0; g < NUM_IN; g++) begin : g_in
    prm_in_mux #(
      .HAS_PORT_B(HAS_PORT_B)
    ) u_mux (
      .sel(in_sel[g]),
      .pin_level(pin_in),
      .level(in_level[g])
    );
  end

  // ==========================================================
  // output routing
  // analog functions never enter here; only digital sources are muxed
  always_comb begin
    next_pin_out = '0;
    next_pin_oe = ~pin_direction_control;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (out_sel[p] == OUT_LATCH) begin
        next_pin_out[p] = port_output_latch[p];
      end else if (out_sel[p] <= OUT_LAST) begin
        // unsupported sources read as zero, reserved codes too
        next_pin_out[p] = periph_out[out_sel[p]-1] & SRC_SUPPORTED[out_sel[p]-1];
        if (periph_drv_en[out_sel[p]-1] && SRC_SUPPORTED[out_sel[p]-1]) begin
          next_pin_oe[p] = periph_drv_oe[out_sel[p]-1];
        end
      end
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe
  always_comb begin
    next_rd_data = '0;
    if (rd_en) begin
      if (addr == ADDR_LOCK) begin
        next_rd_data[LOCK_BIT] = routing_locked_flag;
      end
      for (int i = 0; i < NUM_IN; i++) begin
        if (addr == ADDR_IN_BASE + ADDR_W'(i)) begin
          next_rd_data[SEL_W-1:0] = in_sel[i];
        end
      end
      for (int p = 0; p < NUM_PINS; p++) begin
        if (addr == ADDR_OUT_BASE + ADDR_W'(p)) begin
          next_rd_data[SEL_W-1:0] = out_sel[p];
        end
      end
      for (int k = 0; k < NUM_PORTS; k++) begin
        if (addr == ADDR_PORT_BASE + ADDR_W'(k)) begin
          next_rd_data = pin_in[k*PORT_W +: PORT_W];
        end
      end
    end
  end

  // outputs straight from flip-flops; one cycle of routing latency
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_data <= '0;
      pin_out <= '0;
      pin_oe <= '0;
      periph_in <= '0;
    end else begin
      rd_data <= next_rd_data;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      periph_in <= in_level;
    end
  end

  // ==========================================================
  // checks
  logic key1_wr;
  logic key2_wr;
  assign key1_wr = wr_lock && (wr_data == UNLOCK_KEY1);
  assign key2_wr = wr_lock && (wr_data == UNLOCK_KEY2);

  // ==========================================================
  // check history
  // strobe history of the key bytes and the one-time hold; kept apart from
  // the sequencer so that a fault there cannot hide itself
  logic key1_seen, next_key1_seen;
  logic key2_seen, next_key2_seen;
  logic otl_mode, next_otl_mode;
  logic otl_held, next_otl_held;
  always_comb begin
    next_key1_seen = key1_seen;
    next_key2_seen = key2_seen;
    next_otl_mode = otl_mode;
    next_otl_held = otl_held || (otl_mode && routing_locked_flag);
    if (srst || dev_rst) begin
      next_key1_seen = 1'b0;
      next_key2_seen = 1'b0;
      next_otl_mode = one_time_lock_config;
      next_otl_held = 1'b0;
    end else if (wr_en || rd_en) begin
      // idle cycles keep the history; any strobe replaces it
      next_key1_seen = key1_wr;
      next_key2_seen = key2_wr && key1_seen;
    end
  end

  // registers only
  always_ff @(posedge core_clk) begin
    key1_seen <= next_key1_seen;
    key2_seen <= next_key2_seen;
    otl_mode <= next_otl_mode;
    otl_held <= next_otl_held;
  end

  lock_blocks_a: assert property (@(posedge core_clk) disable iff (srst)
    routing_locked_flag && wr_en && addr == ADDR_OUT_BASE |=> out_sel[0] == $past(out_sel[0]))
    else $error("selector changed while locked");
  key_seq_a: assert property (@(posedge core_clk) disable iff (srst || dev_rst)
    $changed(routing_locked_flag) && !$past(srst) && !$past(dev_rst)
    |-> $past(key2_seen) && $past(wr_lock))
    else $error("lock changed without key sequence");
  lock_read_a: assert property (@(posedge core_clk) disable iff (srst)
    rd_en && addr == ADDR_LOCK |=> rd_data == {7'h00, $past(routing_locked_flag)})
    else $error("lock register read wrong");
  port_read_a: assert property (@(posedge core_clk) disable iff (srst)
    rd_en && addr == ADDR_PORT_BASE |=> rd_data == $past(pin_in[7:0]))
    else $error("port read not pin level");
  sel_upper_a: assert property (@(posedge core_clk) disable iff (srst)
    rd_en && addr == ADDR_IN_BASE |=> rd_data[7:5] == 3'h0 && rd_data[4:0] == $past(in_sel[0]))
    else $error("input selector read wrong");
  in_route_a: assert property (@(posedge core_clk) disable iff (srst)
    in_sel[0][PORT_MSB:PORT_LSB] == PORT_A |=> periph_in[0] == $past(pin_in[in_sel[0][BIT_MSB:0]]))
    else $error("input not routed from selected pin");
  latch_out_a: assert property (@(posedge core_clk) disable iff (srst)
    out_sel[0] == OUT_LATCH |=> pin_out[0] == $past(port_output_latch[0]))
    else $error("latch not routed to pin");
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (srst)
    out_sel[0] > OUT_LAST |=> !pin_out[0])
    else $error("reserved code drove pin");
  dir_keep_a: assert property (@(posedge core_clk) disable iff (srst)
    out_sel[0] == OUT_LATCH |=> pin_oe[0] == !$past(pin_direction_control[0]))
    else $error("direction control lost");
  por_default_a: assert property (@(posedge core_clk)
    srst |=> out_sel[0] == OUT_SEL_RST && in_sel[2] == IN_SEL_RST[2])
    else $error("power-on default missing");
  dev_keep_a: assert property (@(posedge core_clk) disable iff (srst)
    dev_rst |=> in_sel[0] == $past(in_sel[0]) && out_sel[0] == $past(out_sel[0]))
    else $error("device reset touched selections");
  // selectors 0 to 2 and pin 0 stand for the rest; the bench covers every index
  out_read_a: assert property (@(posedge core_clk) disable iff (srst)
    rd_en && addr == ADDR_OUT_BASE |=> rd_data == {3'h0, $past(out_sel[0])})
    else $error("output selector read wrong");
  locked_in_a: assert property (@(posedge core_clk) disable iff (srst)
    routing_locked_flag && wr_en && addr == ADDR_IN_BASE |=> in_sel[0] == $past(in_sel[0]))
    else $error("input selector changed while locked");
  port_c_a: assert property (@(posedge core_clk) disable iff (srst)
    in_sel[1][PORT_MSB:PORT_LSB] == PORT_C |=> periph_in[1] == $past(pin_in[{PORT_C, in_sel[1][BIT_MSB:0]}]))
    else $error("port C input not routed");
  port_b_a: assert property (@(posedge core_clk) disable iff (srst)
    in_sel[2][PORT_MSB:PORT_LSB] == PORT_B
    |=> periph_in[2] == (HAS_PORT_B && $past(pin_in[{PORT_B, in_sel[2][BIT_MSB:0]}])))
    else $error("port B input wrong");
  reserved_port_a: assert property (@(posedge core_clk) disable iff (srst)
    &in_sel[0][PORT_MSB:PORT_LSB] |=> !periph_in[0])
    else $error("reserved port code routed a pin");
  in_shared_a: assert property (@(posedge core_clk) disable iff (srst)
    in_sel[0] == in_sel[1] |=> periph_in[0] == periph_in[1])
    else $error("shared pin gave different levels");
  dir_reserved_a: assert property (@(posedge core_clk) disable iff (srst)
    out_sel[0] > OUT_LAST |=> pin_oe[0] == !$past(pin_direction_control[0]))
    else $error("reserved code took the driver");
  lock_quiet_a: assert property (@(posedge core_clk) disable iff (srst || dev_rst)
    !wr_lock |=> $stable(routing_locked_flag))
    else $error("lock moved without a lock write");
  otl_hold_a: assert property (@(posedge core_clk) disable iff (srst || dev_rst)
    otl_held |=> routing_locked_flag)
    else $error("one-time lock released");

  unlock_set_c: cover property (@(posedge core_clk) disable iff (srst)
    key1_wr ##1 key2_wr ##1 wr_lock ##1 routing_locked_flag);
  locked_write_c: cover property (@(posedge core_clk) disable iff (srst)
    routing_locked_flag && wr_en && addr == ADDR_IN_BASE);
  override_c: cover property (@(posedge core_clk) disable iff (srst)
    out_sel[0] != OUT_LATCH && out_sel[0] <= OUT_LAST && periph_drv_en[out_sel[0]-1]);
  shared_pin_c: cover property (@(posedge core_clk) disable iff (srst)
    in_sel[0] == in_sel[1]);
  otl_refuse_c: cover property (@(posedge core_clk) disable iff (srst)
    otl_held && wr_lock && !wr_data[LOCK_BIT]);
endmodule : prm_router
`default_nettype wire

// >>> tb/prm_far_model.sv
// far-side model: pin levels, port latches, direction and peripheral outputs
// assumes one core_clk; a fresh pattern every cycle while run is high
`timescale 1ns/100ps
`default_nettype none
module prm_far_model (
  // control
  input wire logic core_clk,
  input wire logic run,
  input wire logic [31:0] seed,
  // pins and peripherals
  output logic [23:0] pin_in,
  output logic [23:0] port_output_latch,
  output logic [23:0] pin_direction_control,
  output logic [9:0] periph_out,
  output logic [9:0] periph_drv_en,
  output logic [9:0] periph_drv_oe
);
  // ====================
  // pattern state: digital levels only, analog select already cleared
  logic [127:0] st;
  logic [31:0] nw;
  assign nw = st[31:0] ^ (st[31:0] << 13) ^ st[127:96] ^ (st[127:96] >> 7);
  // new word after each edge, so every input moves and stale values never linger
  always @(posedge core_clk) begin
    if (!run) begin
      st <= {4{seed}};
    end else begin
      st <= {st[95:0], nw};
    end
  end
  // a pin may carry one peripheral's input and output together
  assign pin_in = st[23:0];
  assign port_output_latch = st[55:32];
  assign pin_direction_control = st[87:64];
  assign periph_out = st[105:96];
  assign periph_drv_en = st[115:106] & st[127:118];
  assign periph_drv_oe = st[65:56];
endmodule : prm_far_model
`default_nettype wire

// >>> tb/tb.sv
// bench: drives the register port, compares every cycle with a reference model
// assumes the far-side model feeds pins and peripherals; default parameters
`timescale 1ns/100ps
`default_nettype none
module tb;
  import prm_pkg::*;
  // ====================
  // stimulus and observed signals
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic dev_rst = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic otl_cfg = 1'b0;
  logic run = 1'b0;
  logic [31:0] seed = 32'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] rd_data, periph_in, pe;
  logic flag;
  logic [23:0] pin_in, latch, dir, pin_out, pin_oe, po, oe;
  logic [9:0] p_out, p_en, p_oe;
  // reference state
  int in_sel[8];
  int out_sel[24];
  int lock, kst, otl_m, err_total, num_checks;
  bit [1:0] used;
  // 125 MHz
  always #4 core_clk = ~core_clk;
  // ====================
  // instances
  prm_router uut (.core_clk(core_clk), .srst(srst), .dev_rst(dev_rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .one_time_lock_config(otl_cfg),
    .routing_locked_flag(flag), .pin_in(pin_in), .port_output_latch(latch), .pin_direction_control(dir),
    .pin_out(pin_out), .pin_oe(pin_oe), .periph_in(periph_in), .periph_out(p_out),
    .periph_drv_en(p_en), .periph_drv_oe(p_oe));
  prm_far_model far (.core_clk(core_clk), .run(run), .seed(seed), .pin_in(pin_in),
    .port_output_latch(latch), .pin_direction_control(dir), .periph_out(p_out),
    .periph_drv_en(p_en), .periph_drv_oe(p_oe));
  // ====================
  // comparison and closing
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  // reference model: outputs from the state before the edge, then register effects
  always @(posedge core_clk) begin : ref_model
    logic [7:0] rdx;
    int a, d, c, lo;
    bit w, r, dr;
    w = wr_en;
    r = rd_en;
    a = addr;
    d = wr_data;
    dr = dev_rst;
    lo = lock;
    for (int i = 0; i < 8; i++) begin
      c = in_sel[i];
      pe[i] = !srst && (c >> 3) < 3 && pin_in[(c >> 3) * 8 + c % 8];
    end
    for (int p = 0; p < 24; p++) begin
      c = out_sel[p];
      po[p] = !srst && (c == 0 ? latch[p] : c <= 10 && p_out[c - 1]);
      oe[p] = !srst && (c >= 1 && c <= 10 && p_en[c - 1] ? p_oe[c - 1] : !dir[p]);
    end
    rdx = 8'h00;
    if (r && !srst) begin
      if (a == 0) rdx = 8'(lo);
      else if (a <= 8) rdx = 8'(in_sel[a - 1]);
      else if (a >= 16 && a < 40) rdx = 8'(out_sel[a - 16]);
      else if (a >= 48 && a < 51) rdx = pin_in[(a - 48) * 8 +: 8];
    end
    // one-time option is only looked at while a reset is applied
    if (srst || dr) begin
      lock = 0;
      kst = 0;
      used = 2'b00;
      otl_m = otl_cfg;
    end else if (w && a == 0) begin
      if (kst == 2 && !(otl_m && (used[1] || used[d[0]]))) lock = d[0];
      if (kst == 2) used[d[0]] = 1'b1;
      kst = (kst == 0 && d == 8'h55) ? 1 : (kst == 1 && d == 8'hAA) ? 2 : 0;
    end else if (w || r) kst = 0;
    if (srst) foreach (in_sel[i]) in_sel[i] = IN_SEL_RST[i];
    if (srst) out_sel = '{default: 0};
    else if (w && !lo && !dr && a >= 1 && a <= 8) in_sel[a - 1] = d % 32;
    else if (w && !lo && !dr && a >= 16 && a < 40) out_sel[a - 16] = d % 32;
    #1;
    check(rd_data, rdx);
    check(flag, lock[0]);
    check(periph_in, pe);
    check(pin_out, po);
    check(pin_oe, oe);
  end
  // ====================
  // bus tasks: one strobe cycle per call, signals change right after the edge
  task automatic bus(input bit w, input bit r, input logic [7:0] a, input logic [7:0] d);
    wr_en <= w;
    rd_en <= r;
    addr <= a;
    wr_data <= d;
    @(posedge core_clk);
  endtask : bus
  task automatic key(input bit v);
    bus(1'b1, 1'b0, 8'h00, 8'h55);
    bus(1'b1, 1'b0, 8'h00, 8'hAA);
    bus(1'b1, 1'b0, 8'h00, {7'h00, v});
  endtask : key
  task automatic rd_all();
    for (int a = 0; a < 52; a++) bus(1'b0, 1'b1, 8'(a), 8'h00);
  endtask : rd_all
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  // ====================
  // main sequence; broken key sequences use bit16 write, bit17 read, else idle
  initial begin : stim
    int a;
    int brk[19];
    brk = '{'h10055, 'h20000, 'h100AA, 'h10001, 'h10055, 'h10307, 'h100AA, 'h10001, 'h10055,
      'h1005A, 'h100AA, 'h10001, 'h10001, 'h10055, 'h0, 'h100AA, 'h0, 'h0, 'h10001};
    void'($urandom(85));
    seed <= $urandom | 32'h1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    run <= 1'b1;
    rd_all();
    bus(1'b0, 1'b1, 8'hFF, 8'h00);
    done("reset values");
    repeat (300) begin
      a = ($urandom % 2) ? 1 + $urandom % 8 : 16 + $urandom % 24;
      bus(1'b1, 1'b0, 8'(a), 8'($urandom));
      bus(1'b0, 1'b1, 8'(a), 8'h00);
    end
    for (int c = 0; c < 32; c++) begin
      bus(1'b1, 1'b0, 8'(1 + c % 8), 8'(c));
      bus(1'b1, 1'b0, 8'(16 + c % 24), 8'(c));
      repeat (3) bus(1'b0, 1'b0, 8'h00, 8'h00);
    end
    done("routing");
    key(1'b1);
    for (int s = 1; s < 40; s++) bus(1'b1, 1'b0, 8'(s), 8'($urandom));
    rd_all();
    key(1'b0);
    foreach (brk[i]) bus(brk[i][16], brk[i][17], brk[i][15:8], brk[i][7:0]);
    key(1'b0);
    done("lock");
    otl_cfg <= 1'b1;
    srst <= 1'b1;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    srst <= 1'b0;
    rd_all();
    for (int k = 0; k < 4; k++) key(k[0]);
    dev_rst <= 1'b1;
    bus(1'b1, 1'b0, 8'h01, 8'h1F);
    dev_rst <= 1'b0;
    rd_all();
    // one-time mode again: a set first, then a clear that must be refused
    key(1'b1);
    key(1'b0);
    otl_cfg <= 1'b0;
    dev_rst <= 1'b1;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    dev_rst <= 1'b0;
    key(1'b1);
    key(1'b0);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    done("one-time lock");
    #2;
    stop_test();
  end
  // hang guard: far beyond the length of the sequence
  initial begin : guard
    #400000;
    err_total++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
